// *** core/ddcc_top.sv ***
// configuration and datapath selection for two down-converters behind the converter cores
// assumes samples, register port and output framer all run on clk; no synchronisers needed
// Behaviour
// - 0x22 to app layer: two converters, I only
// - 0x02 to app layer: two converters, I/Q
// - decimation code 0x02 gives 4, 0x03 gives 8
// - control 0x49: real mixer, 6dB, real, three stages
// - control 0x40: real mixer, 6dB, complex, two stages
// - control 0x4a: real mixer, 6dB, real, four stages
// - converter 0 control conv0_control, converter 1 conv1_control
// - select 0x00: channel A to I and Q
// - select 0x05: channel B to I and Q
`timescale 1ns/10ps
`default_nettype none
module ddcc_top (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire ddcc_pkg::ddcc_req_t reg_req,
  output logic [7:0]               reg_rdata,
  // samples from the converter cores
  input  wire logic                smp_valid,
  output logic                     smp_ready,
  input  wire ddcc_pkg::ddcc_smp_t smp,
  // output stream to the framer
  output logic                     out_valid,
  input  wire logic                out_ready,
  output ddcc_pkg::ddcc_word_t     out_word,
  // status
  output logic                     bypass,
  output logic                     real_only,
  output logic                     conv1_on,
  output logic [3:0]               dec_ratio,
  output logic [3:0]               stage_en0,
  output logic [3:0]               stage_en1
);

  // whole state of the block
  typedef struct packed {
    logic [7:0]                app;      // application layer select
    logic [7:0]                dec;      // chip decimation code
    logic                      app_wr;   // app layer written since reset
    logic                      dec_wr;   // decimation written since reset
    logic [1:0][7:0]           ctl;      // per-converter control
    logic [1:0][7:0]           sel;      // per-converter input select
    logic [1:0][15:0]          frequency_tuning_word;      // tuning words
    logic [1:0][15:0]          phase_offset_word;      // phase offsets
    logic [1:0][15:0]          phase;    // nco accumulators
    logic [1:0][18:0]          acc_i;    // decimation sums, I
    logic [1:0][18:0]          acc_q;    // decimation sums, Q
    logic [2:0]                cnt;      // samples in current output period
    logic                      pend;     // word waiting for the fifo
    ddcc_pkg::ddcc_word_t      word;     // word to push
    logic [7:0]                rdata;    // read data
  } ddcc_st_t;

  ddcc_st_t              s_r;
  ddcc_st_t              s_nxt;
  logic                  fifo_ready;  // fifo filling side ready
  logic                  accept;      // sample taken this cycle
  logic [1:0][15:0]      xi;          // selected I input per converter
  logic [1:0][15:0]      xq;          // selected Q input per converter

  // half-band stages enabled by the two-bit cascade field, stage one in bit 0
  function automatic logic [3:0] hb_stages(input logic [7:0] c);
    unique case (c[ddcc_pkg::CTL_HB_LSB +: 2])
      2'h0: hb_stages = 4'h3;
      2'h1: hb_stages = 4'h7;
      2'h2: hb_stages = 4'hf;
      2'h3: hb_stages = 4'h1;
    endcase
  endfunction

  // decimation code to ratio; other codes mean not decimating
  function automatic logic [3:0] dec_of(input logic [7:0] d);
    if (d == 8'h01)
      dec_of = 4'h2;
    else if (d == ddcc_pkg::DEC_BY4)
      dec_of = 4'h4;
    else if (d == ddcc_pkg::DEC_BY8)
      dec_of = 4'h8;
    else
      dec_of = 4'h1;
  endfunction

  // sign extend a converter sample to the 16-bit path
  function automatic logic [15:0] ext(input logic [13:0] x);
    ext = {{2{x[13]}}, x};
  endfunction

  // coarse quadrant rotation; cheap stand-in for the nco multiply
  function automatic logic [31:0] rot(input logic [15:0] i, input logic [15:0] q, input logic [1:0] quad);
    unique case (quad)
      2'h0: rot = {i, q};
      2'h1: rot = {q, 16'h0000 - i};
      2'h2: rot = {16'h0000 - i, 16'h0000 - q};
      2'h3: rot = {16'h0000 - q, i};
    endcase
  endfunction

  // status drawn from registers
  assign bypass    = !(s_r.app_wr && s_r.dec_wr) || dec_of(s_r.dec) == 4'h1;
  assign real_only = s_r.app[ddcc_pkg::APP_REAL_BIT];
  assign conv1_on  = s_r.app[1:0] >= ddcc_pkg::APP_TWO_CONV;
  assign dec_ratio = dec_of(s_r.dec);
  assign stage_en0 = hb_stages(s_r.ctl[0]);
  assign stage_en1 = hb_stages(s_r.ctl[1]);
  assign reg_rdata = s_r.rdata;

  // a pending word blocks new samples only while the fifo refuses it
  assign smp_ready = !s_r.pend || fifo_ready;
  assign accept    = smp_valid && smp_ready;

  // input routing per converter
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      xi[k] = s_r.sel[k][ddcc_pkg::SEL_I_FROM_B] ? ext(smp.b) : ext(smp.a);
      xq[k] = s_r.sel[k][ddcc_pkg::SEL_Q_FROM_B] ? ext(smp.b) : ext(smp.a);
    end
  end

  // next state: registers, nco, mixing and decimation
  always_comb
  begin
    logic [1:0][15:0] ph;
    logic [31:0]      m;
    logic [15:0]      mi;
    logic [15:0]      mq;
    logic [1:0]       sh;
    ph    = '0;
    m     = '0;
    mi    = '0;
    mq    = '0;
    sh    = '0;
    s_nxt = s_r;
    // register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        ddcc_pkg::OFS_APP_LAYER:
        begin
          s_nxt.app    = reg_req.wdata;
          s_nxt.app_wr = 1'b1;
        end
        ddcc_pkg::OFS_DECIMATION:
        begin
          s_nxt.dec    = reg_req.wdata;
          s_nxt.dec_wr = 1'b1;
        end
        ddcc_pkg::OFS_CTL0:   s_nxt.ctl[0]       = reg_req.wdata;
        ddcc_pkg::OFS_SEL0:   s_nxt.sel[0]       = reg_req.wdata;
        ddcc_pkg::OFS_FTW0_A: s_nxt.frequency_tuning_word[0][7:0]  = reg_req.wdata;
        ddcc_pkg::OFS_FTW0_B: s_nxt.frequency_tuning_word[0][15:8] = reg_req.wdata;
        ddcc_pkg::OFS_POW0_A: s_nxt.phase_offset_word[0][7:0]  = reg_req.wdata;
        ddcc_pkg::OFS_POW0_B: s_nxt.phase_offset_word[0][15:8] = reg_req.wdata;
        ddcc_pkg::OFS_CTL1:   s_nxt.ctl[1]       = reg_req.wdata;
        ddcc_pkg::OFS_SEL1:   s_nxt.sel[1]       = reg_req.wdata;
        ddcc_pkg::OFS_FTW1_A: s_nxt.frequency_tuning_word[1][7:0]  = reg_req.wdata;
        ddcc_pkg::OFS_FTW1_B: s_nxt.frequency_tuning_word[1][15:8] = reg_req.wdata;
        ddcc_pkg::OFS_POW1_A: s_nxt.phase_offset_word[1][7:0]  = reg_req.wdata;
        ddcc_pkg::OFS_POW1_B: s_nxt.phase_offset_word[1][15:8] = reg_req.wdata;
        default: ; // unmapped writes are dropped
      endcase
    end
    // register reads, unmapped reads as zero
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        ddcc_pkg::OFS_APP_LAYER:  s_nxt.rdata = s_r.app;
        ddcc_pkg::OFS_DECIMATION: s_nxt.rdata = s_r.dec;
        ddcc_pkg::OFS_CTL0:       s_nxt.rdata = s_r.ctl[0];
        ddcc_pkg::OFS_SEL0:       s_nxt.rdata = s_r.sel[0];
        ddcc_pkg::OFS_FTW0_A:     s_nxt.rdata = s_r.frequency_tuning_word[0][7:0];
        ddcc_pkg::OFS_FTW0_B:     s_nxt.rdata = s_r.frequency_tuning_word[0][15:8];
        ddcc_pkg::OFS_POW0_A:     s_nxt.rdata = s_r.phase_offset_word[0][7:0];
        ddcc_pkg::OFS_POW0_B:     s_nxt.rdata = s_r.phase_offset_word[0][15:8];
        ddcc_pkg::OFS_CTL1:       s_nxt.rdata = s_r.ctl[1];
        ddcc_pkg::OFS_SEL1:       s_nxt.rdata = s_r.sel[1];
        ddcc_pkg::OFS_FTW1_A:     s_nxt.rdata = s_r.frequency_tuning_word[1][7:0];
        ddcc_pkg::OFS_FTW1_B:     s_nxt.rdata = s_r.frequency_tuning_word[1][15:8];
        ddcc_pkg::OFS_POW1_A:     s_nxt.rdata = s_r.phase_offset_word[1][7:0];
        ddcc_pkg::OFS_POW1_B:     s_nxt.rdata = s_r.phase_offset_word[1][15:8];
        default:                  s_nxt.rdata = 8'h00;
      endcase
    end
    // pending word leaves when the fifo takes it
    if (s_r.pend && fifo_ready)
    begin
      s_nxt.pend = 1'b0;
    end
    if (accept)
    begin
      if (bypass)
      begin
        // raw channels straight through, one word per sample
        s_nxt.word = '{i0: ext(smp.a), q0: ext(smp.b), i1: ext(smp.a), q1: ext(smp.b)};
        s_nxt.pend = 1'b1;
        s_nxt.cnt  = '0;
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          // nco advances by the tuning word, offset by the phase word
          s_nxt.phase[k] = s_r.phase[k] + s_r.frequency_tuning_word[k];
          ph[k]          = s_r.phase[k] + s_r.phase_offset_word[k];
          // real mixer sees no Q input
          m  = rot(xi[k], s_r.ctl[k][ddcc_pkg::CTL_CPLX_MIX] ? xq[k] : 16'h0000, ph[k][15:14]);
          mi = s_r.ctl[k][ddcc_pkg::CTL_GAIN6] ? {m[30:16], 1'b0} : m[31:16];
          mq = s_r.ctl[k][ddcc_pkg::CTL_GAIN6] ? {m[14:0], 1'b0} : m[15:0];
          s_nxt.acc_i[k] = s_r.acc_i[k] + {{3{mi[15]}}, mi};
          s_nxt.acc_q[k] = s_r.acc_q[k] + {{3{mq[15]}}, mq};
        end
        s_nxt.cnt = s_r.cnt + 1'b1;
        // emit one averaged word per decimation period
        if ({1'b0, s_r.cnt} == dec_ratio - 4'h1)
        begin
          sh = s_r.dec[1:0];
          s_nxt.word.i0 = 16'(s_nxt.acc_i[0] >>> sh);
          s_nxt.word.q0 = (real_only || s_r.ctl[0][ddcc_pkg::CTL_REAL_OUT]) ? 16'h0000
                          : 16'(s_nxt.acc_q[0] >>> sh);
          s_nxt.word.i1 = conv1_on ? 16'(s_nxt.acc_i[1] >>> sh) : 16'h0000;
          s_nxt.word.q1 = (!conv1_on || real_only || s_r.ctl[1][ddcc_pkg::CTL_REAL_OUT]) ? 16'h0000
                          : 16'(s_nxt.acc_q[1] >>> sh);
          s_nxt.acc_i = '0;
          s_nxt.acc_q = '0;
          s_nxt.cnt   = '0;
          s_nxt.pend  = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0; // all registers reset to ddcc_pkg::RST_REG, block in bypass
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // output buffer; a stalled framer backs up into smp_ready
  ddcc_fifo #(
    .W ($bits(ddcc_pkg::ddcc_word_t)),
    .D (ddcc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (s_r.pend),
    .in_ready  (fifo_ready),
    .in_data   (s_r.word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_word)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_app_real;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_APP_LAYER && reg_req.wdata == ddcc_pkg::APP_TWO_REAL
      |=> real_only && conv1_on;
  endproperty
  a_app_real: assert property (p_app_real) else $error("app 0x22 not two converters I only");

  property p_app_iq;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_APP_LAYER && reg_req.wdata == ddcc_pkg::APP_TWO_IQ
      |=> !real_only && conv1_on;
  endproperty
  a_app_iq: assert property (p_app_iq) else $error("app 0x02 not two converters I/Q");

  property p_dec;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_DECIMATION && reg_req.wdata inside {8'h02, 8'h03}
      |=> dec_ratio == ($past(reg_req.wdata[0]) ? 4'h8 : 4'h4);
  endproperty
  a_dec: assert property (p_dec) else $error("decimation ratio wrong");

  property p_ctl49;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_CTL0 && reg_req.wdata == ddcc_pkg::CTL_REAL_HB321
      |=> stage_en0 == 4'h7 && !s_r.ctl[0][ddcc_pkg::CTL_CPLX_MIX] && s_r.ctl[0][ddcc_pkg::CTL_REAL_OUT];
  endproperty
  a_ctl49: assert property (p_ctl49) else $error("control 0x49 decode wrong");

  property p_ctl40;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_CTL0 && reg_req.wdata == ddcc_pkg::CTL_CPLX_HB21
      |=> stage_en0 == 4'h3 && s_r.ctl[0][ddcc_pkg::CTL_GAIN6] && !s_r.ctl[0][ddcc_pkg::CTL_REAL_OUT];
  endproperty
  a_ctl40: assert property (p_ctl40) else $error("control 0x40 decode wrong");

  property p_ctl4a;
    reg_req.wr && reg_req.addr == ddcc_pkg::OFS_CTL1 && reg_req.wdata == ddcc_pkg::CTL_REAL_HB4321
      |=> stage_en1 == 4'hf ##1 stage_en1 == 4'hf || $past(reg_req.wr);
  endproperty
  a_ctl4a: assert property (p_ctl4a) else $error("control 0x4a at conv1_control decode wrong");

  property p_sel_a;
    s_r.sel[0] == ddcc_pkg::SEL_BOTH_A |-> xi[0] == ext(smp.a) && xq[0] == ext(smp.a);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("select 0x00 not channel A");

  property p_sel_b;
    s_r.sel[1] == ddcc_pkg::SEL_BOTH_B |-> xi[1] == ext(smp.b) && xq[1] == ext(smp.b);
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("select 0x05 not channel B");

  property p_bypass;
    bypass && accept |=> s_r.pend && s_r.word.i0 == ext($past(smp.a)) && s_r.word.q0 == ext($past(smp.b));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass word not raw sample");

  property p_reset_bypass;
    $rose(!rst) |-> bypass [*2];
  endproperty
  a_reset_bypass: assert property (p_reset_bypass) else $error("not bypassed after reset");

endmodule // ddcc_top
`default_nettype wire

// *** core/ddcc_pkg.sv ***
// package for the dual down-converter configuration block
// assumes one sample clock shared by the converter cores, the register port and the output framer
package ddcc_pkg;

  // register offsets
  localparam logic [11:0] OFS_APP_LAYER   = 12'h200;
  localparam logic [11:0] OFS_DECIMATION  = 12'h201;
  localparam logic [11:0] OFS_CTL0        = 12'h310;
  localparam logic [11:0] OFS_SEL0        = 12'h311;
  localparam logic [11:0] OFS_FTW0_A      = 12'h314;
  localparam logic [11:0] OFS_FTW0_B      = 12'h315;
  localparam logic [11:0] OFS_POW0_A      = 12'h320;
  localparam logic [11:0] OFS_POW0_B      = 12'h321;
  localparam logic [11:0] OFS_CTL1        = 12'h330;
  localparam logic [11:0] OFS_SEL1        = 12'h331;
  localparam logic [11:0] OFS_FTW1_A      = 12'h334;
  localparam logic [11:0] OFS_FTW1_B      = 12'h335;
  localparam logic [11:0] OFS_POW1_A      = 12'h340;
  localparam logic [11:0] OFS_POW1_B      = 12'h341;

  // reset values
  localparam logic [7:0]  RST_REG         = 8'h00;

  // application layer fields
  localparam int          APP_REAL_BIT    = 5;      // set: I only output
  localparam logic [1:0]  APP_TWO_CONV    = 2'h2;   // two down-converters active
  localparam logic [7:0]  APP_TWO_REAL    = 8'h22;
  localparam logic [7:0]  APP_TWO_IQ      = 8'h02;

  // decimation codes
  localparam logic [7:0]  DEC_BY4         = 8'h02;
  localparam logic [7:0]  DEC_BY8         = 8'h03;

  // per-converter control fields
  localparam int          CTL_CPLX_MIX    = 7;      // set: complex mixer, clear: real mixer
  localparam int          CTL_GAIN6       = 6;      // set: 6 dB gain
  localparam int          CTL_REAL_OUT    = 3;      // set: real output
  localparam int          CTL_HB_LSB      = 0;      // two-bit half-band cascade field
  localparam logic [7:0]  CTL_REAL_HB321  = 8'h49;
  localparam logic [7:0]  CTL_CPLX_HB21   = 8'h40;
  localparam logic [7:0]  CTL_REAL_HB4321 = 8'h4a;

  // input select fields
  localparam int          SEL_I_FROM_B    = 0;
  localparam int          SEL_Q_FROM_B    = 2;
  localparam logic [7:0]  SEL_BOTH_A      = 8'h00;
  localparam logic [7:0]  SEL_BOTH_B      = 8'h05;

  // fifo
  localparam int          FIFO_DEPTH      = 8;

  // register port request
  typedef struct packed {
    logic        wr;      // one-cycle write strobe
    logic        rd;      // one-cycle read strobe
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ddcc_req_t;

  // one sample pair from the converter cores
  typedef struct packed {
    logic signed [13:0] a;
    logic signed [13:0] b;
  } ddcc_smp_t;

  // one output word, both down-converters
  typedef struct packed {
    logic signed [15:0] i0;
    logic signed [15:0] q0;
    logic signed [15:0] i1;
    logic signed [15:0] q1;
  } ddcc_word_t;

endpackage

// *** core/ddcc_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
// assumes the filling and draining sides share clk
`timescale 1ns/10ps
`default_nettype none
module ddcc_fifo #(
  parameter int W = 64,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  // whole state of the fifo
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // storage words
    logic [AW-1:0]       wp;    // write index
    logic [AW-1:0]       rp;    // read index
    logic [AW:0]         cnt;   // words held
  } ddcc_fifo_st_t;

  ddcc_fifo_st_t s_r;
  ddcc_fifo_st_t s_nxt;
  logic          push;
  logic          pop;

  // handshakes are combinational; data comes straight from storage flops
  assign in_ready  = (s_r.cnt != D[AW:0]);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule // ddcc_fifo
`default_nettype wire

// *** verif/ddcc_partner.sv ***
// far-side model: converter cores supplying sample pairs and a framer taking words
// assumes clk is shared with the block; the bench drives stall and calls send
`timescale 1ns/10ps
`default_nettype none
module ddcc_partner (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // converter cores side
  output logic                      smp_valid,
  input  wire logic                 smp_ready,
  output ddcc_pkg::ddcc_smp_t       smp,
  // framer side
  input  wire logic                 out_valid,
  output logic                      out_ready,
  input  wire ddcc_pkg::ddcc_word_t out_word,
  input  wire logic                 stall
);
  ddcc_pkg::ddcc_word_t got[$];  // words taken by the framer, in order

  initial
  begin
    smp_valid = 1'b0;
    smp       = '0;
  end

  // hold one pair until accepted; ready is combinational and settles by the falling edge
  task automatic send(input logic [13:0] a, input logic [13:0] b);
    int n;
    n = 0;
    @(posedge clk);
    smp_valid <= 1'b1;
    smp       <= {a, b};
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!smp_ready && n < 1000);
    @(posedge clk);
    smp_valid <= 1'b0;
    smp       <= ~{a, b};  // stale lines never repeat the last pair
  endtask

  // framer: stalls on request, records every word handed over
  always @(posedge clk)
  begin
    out_ready <= !stall && !rst;
    if (out_valid && out_ready)
      got.push_back(out_word);
  end
endmodule // ddcc_partner
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the dual down-converter configuration block
// assumes ddcc_pkg, ddcc_fifo, ddcc_top and ddcc_partner are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                 clk;
  logic                 rst;
  ddcc_pkg::ddcc_req_t  reg_req;
  logic [7:0]           reg_rdata;
  logic                 smp_valid;
  logic                 smp_ready;
  ddcc_pkg::ddcc_smp_t  smp;
  logic                 out_valid;
  logic                 out_ready;
  ddcc_pkg::ddcc_word_t out_word;
  logic                 bypass;
  logic                 real_only;
  logic                 conv1_on;
  logic [3:0]           dec_ratio;
  logic [3:0]           stage_en0;
  logic [3:0]           stage_en1;
  logic                 stall;       // framer back-pressure
  logic [7:0]           rd;          // last read result
  logic [63:0]          exp_q[$];    // expected bypass words
  logic [11:0]          addrs[14] = '{12'h200, 12'h201, 12'h310, 12'h311, 12'h314, 12'h315, 12'h320,
                                      12'h321, 12'h330, 12'h331, 12'h334, 12'h335, 12'h340, 12'h341};
  logic [7:0]           codes[3] = '{8'h49, 8'h40, 8'h4a};
  logic [3:0]           stages[3] = '{4'h7, 4'h3, 4'hf};
  int                   errors;
  int                   check_count;

  ddcc_top ddcc_top_inst (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .bypass(bypass), .real_only(real_only),
    .conv1_on(conv1_on), .dec_ratio(dec_ratio), .stage_en0(stage_en0), .stage_en1(stage_en1));

  ddcc_partner ddcc_partner_inst (.clk(clk), .rst(rst), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp(smp), .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .stall(stall));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare, count and report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // status outputs packed as bypass, real_only, conv1_on, ratio, stages 0 and 1
  task automatic stat(input logic [14:0] e);
    chk(64'({bypass, real_only, conv1_on, dec_ratio, stage_en0, stage_en1}), 64'(e));
  endtask

  // one-cycle write strobe; settles past the taking edge
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe; data is registered at the taking edge
  task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // sign extension of a converter sample to a word lane
  function automatic logic [15:0] ext(input logic [13:0] x);
    return {{2{x[13]}}, x};
  endfunction

  // wait for n words at the framer, bounded
  task automatic wait_words(input int n);
    for (int k = 0; k < 200 && ddcc_partner_inst.got.size() < n; k++)
      @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang is cut short well past the expected few hundred cycles
  initial
  begin
    #100000;
    errors++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    stall = 1'b0;
    reg_req = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    // reset state: path bypassed and undecimated
    stat({1'b1, 1'b0, 1'b0, 4'h1, 4'h3, 4'h3});
    reg_rd(12'h200, rd);
    chk(64'(rd), 64'h0);
    $display("test reset done");

    // bypass with the framer stalled: eight buffered, one pending, then refusal
    stall = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      ddcc_partner_inst.send(14'(k * 611 - 2000), 14'(900 - k * 517));
      exp_q.push_back({ext(14'(k * 611 - 2000)), ext(14'(900 - k * 517)),
                       ext(14'(k * 611 - 2000)), ext(14'(900 - k * 517))});
    end
    repeat (3) @(posedge clk);
    #1;
    chk(64'({smp_ready, out_valid}), 64'h1);
    stall = 1'b0;
    wait_words(9);
    for (int k = 0; k < 9; k++)
      chk(ddcc_partner_inst.got[k], exp_q[k]);
    repeat (2) @(posedge clk);
    #1;
    chk(64'(out_valid), 64'h0);
    $display("test bypass and buffer done");

    // every register holds what was written; an unmapped place reads zero
    for (int i = 0; i < 14; i++)
    begin
      reg_wr(addrs[i], 8'h5a ^ 8'(i));
      reg_rd(addrs[i], rd);
      chk(64'(rd), 64'(8'h5a ^ 8'(i)));
      reg_wr(addrs[i], 8'h00);
    end
    reg_wr(12'h202, 8'hff);
    reg_rd(12'h202, rd);
    chk(64'(rd), 64'h0);
    $display("test register access done");

    // two converters, real only, decimate by 4
    reg_wr(12'h200, 8'h22);
    chk(64'({real_only, conv1_on}), 64'h3);
    reg_wr(12'h201, 8'h02);
    stat({1'b0, 1'b1, 1'b1, 4'h4, 4'h3, 4'h3});
    for (int c = 0; c < 3; c++)
    begin
      reg_wr(12'h310, codes[c]);
      chk(64'(stage_en0), 64'(stages[c]));
      reg_wr(12'h330, codes[c]);
      chk(64'({stage_en0, stage_en1}), 64'({stages[c], stages[c]}));
    end
    reg_wr(12'h310, 8'h49);
    reg_wr(12'h330, 8'h49);
    stat({1'b0, 1'b1, 1'b1, 4'h4, 4'h7, 4'h7});
    reg_wr(12'h311, 8'h00);
    reg_wr(12'h331, 8'h05);
    ddcc_partner_inst.got.delete();
    for (int k = 0; k < 4; k++)
      ddcc_partner_inst.send(14'(100 + 2 * k), 14'(-50 - 2 * k));
    wait_words(1);
    chk(ddcc_partner_inst.got[0], {16'h00ce, 16'h0000, 16'hff96, 16'h0000});
    $display("test real by 4 done");

    // two converters, I/Q, decimate by 8, quarter-turn phase on converter 0
    reg_wr(12'h200, 8'h02);
    reg_wr(12'h201, 8'h03);
    reg_wr(12'h310, 8'h40);
    reg_wr(12'h330, 8'h40);
    reg_wr(12'h321, 8'h40);
    stat({1'b0, 1'b0, 1'b1, 4'h8, 4'h3, 4'h3});
    ddcc_partner_inst.got.delete();
    for (int k = 0; k < 8; k++)
      ddcc_partner_inst.send(14'(100 + 2 * k), 14'(-50 - 2 * k));
    wait_words(1);
    chk(ddcc_partner_inst.got[0], {16'h0000, 16'hff2a, 16'hff8e, 16'h0000});
    $display("test complex by 8 done");

    // complex mixer, I/Q, decimate by 2; half turn on converter 0, three quarters on converter 1
    reg_wr(12'h201, 8'h01);
    reg_wr(12'h310, 8'h83);
    reg_wr(12'h330, 8'h83);
    reg_wr(12'h311, 8'h04);
    reg_wr(12'h321, 8'h80);
    reg_wr(12'h341, 8'hc0);
    stat({1'b0, 1'b0, 1'b1, 4'h2, 4'h1, 4'h1});
    ddcc_partner_inst.got.delete();
    for (int k = 0; k < 2; k++)
      ddcc_partner_inst.send(14'(100 + 2 * k), 14'(-50 - 2 * k));
    wait_words(1);
    chk(ddcc_partner_inst.got[0], {16'hff9b, 16'h0033, 16'h0033, 16'hffcd});
    $display("test complex mixer by 2 done");

    // reset in mid-run clears every register and returns the path to bypass
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    stat({1'b1, 1'b0, 1'b0, 4'h1, 4'h3, 4'h3});
    reg_rd(12'h310, rd);
    chk(64'(rd), 64'h0);
    $display("test second reset done");
    conclude();
  end
endmodule // tb
`default_nettype wire
